/* File: hdl/agc_pkg.sv */
// Shared constants, register map and state codes of the gain step control.
package agc_pkg;
	// Clock and time base.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_NS       = 100000;
	localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned RETRY_US      = 110;
	localparam int unsigned RETRY_CYCLES  = RETRY_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned PROBE_NS      = 1000;
	localparam int unsigned PROBE_CYCLES  = PROBE_NS / CLK_PERIOD_NS;

	// Widths.
	localparam int unsigned AW  = 8;
	localparam int unsigned DW  = 16;
	localparam int unsigned EW  = 8;
	localparam int unsigned GW  = 7;
	localparam int unsigned TW  = 16;

	// Register offsets.
	localparam logic [7:0] OFS_CTRL1    = 8'h01;
	localparam logic [7:0] OFS_ATTACK   = 8'h02;
	localparam logic [7:0] OFS_RELEASE  = 8'h03;
	localparam logic [7:0] OFS_HOLD     = 8'h04;
	localparam logic [7:0] OFS_GATE     = 8'h05;
	localparam logic [7:0] OFS_LIMIT    = 8'h06;
	localparam logic [7:0] OFS_TARGET   = 8'h07;
	localparam logic [7:0] OFS_MAXGAIN  = 8'h08;
	localparam logic [7:0] OFS_GAIN     = 8'h09;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0A;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0B;

	// Field positions.
	localparam int unsigned CTRL1_HOLD_EN = 0;
	localparam int unsigned CTRL1_FAULT   = 3;
	localparam int unsigned IRQ_SHORT     = 0;
	localparam int unsigned IRQ_DOWN      = 1;
	localparam int unsigned IRQ_UP        = 2;
	localparam int unsigned IRQ_W         = 3;

	// Reset values; gain is counted in half-decibel steps.
	localparam logic        HOLD_EN_RST  = 1'h1;
	localparam logic [15:0] ATTACK_RST   = 16'h0001;
	localparam logic [15:0] RELEASE_RST  = 16'h0064;
	localparam logic [15:0] HOLD_RST     = 16'h0190;
	localparam logic [7:0]  GATE_RST     = 8'h04;
	localparam logic [7:0]  LIMIT_RST    = 8'hC0;
	localparam logic [7:0]  TARGET_RST   = 8'h60;
	localparam logic [6:0]  MAXGAIN_RST  = 7'h3C;
	localparam logic [6:0]  GAIN_RST     = 7'h0C;
	localparam logic [6:0]  GAIN_STEP    = 7'h01;

	// Short-circuit recovery states, one-hot.
	typedef enum logic [2:0] {
		SC_RUN   = 3'b001,
		SC_OFF   = 3'b010,
		SC_PROBE = 3'b100
	} sc_state_e;
endpackage : agc_pkg

/* File: hdl/step_timer_if.sv */
// Link between the gain stepper and its interval timer.
interface step_timer_if;
	logic                  restart;
	logic                  after_dec;
	logic                  hold_en;
	logic [agc_pkg::TW-1:0] attack_ivl;
	logic [agc_pkg::TW-1:0] release_ivl;
	logic [agc_pkg::TW-1:0] hold_ivl;
	logic                  dec_ok;
	logic                  inc_ok;

	modport ctrl (
		output restart, after_dec, hold_en, attack_ivl, release_ivl, hold_ivl,
		input  dec_ok, inc_ok
	);
	modport timer (
		input  restart, after_dec, hold_en, attack_ivl, release_ivl, hold_ivl,
		output dec_ok, inc_ok
	);
endinterface : step_timer_if

/* File: hdl/step_timer.sv */
// Interval timer that paces gain decreases and increases.
module step_timer #(
	parameter int unsigned TICK_CYCLES = agc_pkg::TICK_CYCLES
) (
	input wire logic  clk_i,   // System clock.
	input wire logic  reset_i, // Synchronous reset, active high.
	step_timer_if.timer tif    // Pacing link to the stepper.
);
	localparam int unsigned PW = $clog2(TICK_CYCLES);
	localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

	logic [PW-1:0]          pre_reg;
	logic [agc_pkg::TW-1:0] ticks_reg;
	logic                   tick;
	logic                   use_hold;
	logic [agc_pkg::TW-1:0] inc_ivl;

	// The prescaler restarts too, so no interval is cut short by a part tick.
	always_ff @(posedge clk_i) begin
		if (reset_i || tif.restart) begin // [R05]
			pre_reg <= '0;
		end else if (pre_reg == PRE_LAST) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + PW'(1);
		end
	end

	assign tick = (pre_reg == PRE_LAST);

	// Ticks since the last gain change; saturates rather than wrapping.
	always_ff @(posedge clk_i) begin
		if (reset_i || tif.restart) begin // [R05]
			ticks_reg <= '0;
		end else if (tick && (ticks_reg != '1)) begin
			ticks_reg <= ticks_reg + agc_pkg::TW'(1);
		end
	end

	// Hold replaces release only once after a decrease, if enabled and longer.
	assign use_hold = tif.hold_en && tif.after_dec
		&& (tif.hold_ivl > tif.release_ivl); // [R06] [R08] [R09]
	assign inc_ivl = use_hold ? tif.hold_ivl : tif.release_ivl; // [R07]
	assign tif.dec_ok = (ticks_reg >= tif.attack_ivl); // [R03]
	assign tif.inc_ok = (ticks_reg >= inc_ivl); // [R04]

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_timer_restart: assert property (tif.restart |=> ticks_reg == '0) // [R05]
		else $error("Interval count not cleared by a gain change.");
	a_hold_blocks_inc: assert property ( // [R06]
		(tif.hold_en && tif.after_dec && tif.hold_ivl > tif.release_ivl
		&& ticks_reg < tif.hold_ivl) |-> !tif.inc_ok)
		else $error("Increase allowed before the hold interval.");
	a_release_no_hold: assert property ( // [R08]
		(!tif.hold_en && ticks_reg >= tif.release_ivl) |-> tif.inc_ok)
		else $error("Release interval ignored with hold off.");
	a_short_hold_ign: assert property ( // [R09]
		(tif.hold_ivl <= tif.release_ivl && ticks_reg < tif.release_ivl)
		|-> !tif.inc_ok)
		else $error("Short hold interval shortened the release.");
endmodule : step_timer

/* File: hdl/agc_gain_step.sv */
// Gain step control with noise gate, ceiling, pacing and short recovery.
// What this block does
// R01: Gain is frozen while the envelope is at or below the noise gate.
// R02: Gain never steps above the programmed maximum gain.
// R03: Decreases are spaced by at least the attack interval.
// R04: Increases are spaced by at least the release interval.
// R05: Every gain change restarts all interval timing from zero.
// R06: First increase after a decrease waits for the hold interval.
// R07: Further increases after that are paced by the release interval.
// R08: With hold disabled, release paces every increase.
// R09: Hold applies only when enabled and longer than release.
// R10: Software keeps attack at least a hundred times shorter than others.
// R11: Software keeps hold no shorter than release.
// R12: A short turns the output off and retries every 110 microseconds.
// R13: Retries go on until the short is gone, then normal running resumes.
// R14: Fault flag, bit three of control one, stays until software clears it.
// R15: Each gain change is exactly one half-decibel step.
// R16: Decrease above limiter level, increase below target, each once timed.
module agc_gain_step #(
	parameter int unsigned TICK_CYCLES  = agc_pkg::TICK_CYCLES,
	parameter int unsigned RETRY_CYCLES = agc_pkg::RETRY_CYCLES
) (
	input  wire logic                 CLK_I,    // System clock, 100 MHz.
	input  wire logic                 RESET_I,  // Synchronous reset.
	input  wire logic [agc_pkg::AW-1:0] ADDR_I, // Register address.
	input  wire logic [agc_pkg::DW-1:0] WDATA_I, // Register write data.
	input  wire logic                 WR_I,     // Write strobe.
	input  wire logic                 RD_I,     // Read strobe.
	output logic      [agc_pkg::DW-1:0] RDATA_O, // Read data, next cycle.
	input  wire logic [agc_pkg::EW-1:0] ENV_I,  // Detected envelope.
	input  wire logic                 SHORT_I,  // Short detect pin.
	output logic      [agc_pkg::GW-1:0] GAIN_O, // Applied gain, half-dB.
	output logic                      OUT_EN_O, // Output stage enable.
	output logic                      FAULT_O,  // Sticky short fault.
	output logic                      IRQ_O     // Interrupt, level.
);
	// One counter times both the retry and the probe, so it must fit both.
	localparam int unsigned CMAX = (RETRY_CYCLES > agc_pkg::PROBE_CYCLES)
		? RETRY_CYCLES : agc_pkg::PROBE_CYCLES;
	localparam int unsigned CW = $clog2(CMAX + 1);
	localparam logic [CW-1:0] RETRY_LAST = CW'(RETRY_CYCLES - 1);
	localparam logic [CW-1:0] PROBE_LAST = CW'(agc_pkg::PROBE_CYCLES - 1);

	step_timer_if tif ();

	logic                   hold_en_reg;
	logic [agc_pkg::TW-1:0] attack_reg;
	logic [agc_pkg::TW-1:0] release_reg;
	logic [agc_pkg::TW-1:0] hold_reg;
	logic [agc_pkg::EW-1:0] gate_reg;
	logic [agc_pkg::EW-1:0] limit_reg;
	logic [agc_pkg::EW-1:0] target_reg;
	logic [agc_pkg::GW-1:0] max_reg;
	logic [agc_pkg::GW-1:0] gain_reg;
	logic                   after_dec_reg;
	logic                   fault_reg;
	logic [agc_pkg::IRQ_W-1:0] stat_reg;
	logic [agc_pkg::IRQ_W-1:0] mask_reg;
	logic [agc_pkg::IRQ_W-1:0] stat_next;
	logic                   irq_reg;
	logic [agc_pkg::DW-1:0] rdata_reg;
	logic [agc_pkg::DW-1:0] rdata_next;
	logic                   short_meta_reg;
	logic                   short_reg;
	agc_pkg::sc_state_e     sc_reg;
	logic [CW-1:0]          sc_cnt_reg;
	logic                   out_en_reg;
	logic                   gated;
	logic                   want_dec;
	logic                   dec_fire;
	logic                   inc_fire;
	logic                   short_event;
	logic                   wr_ctrl1;
	logic                   wr_stat;

	// Timer link.
	assign tif.restart     = dec_fire || inc_fire; // [R05]
	assign tif.after_dec   = after_dec_reg;
	assign tif.hold_en     = hold_en_reg;
	assign tif.attack_ivl  = attack_reg;
	assign tif.release_ivl = release_reg;
	assign tif.hold_ivl    = hold_reg;

	step_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.clk_i   (CLK_I),
		.reset_i (RESET_I),
		.tif     (tif)
	);

	// Step decisions. A gain above a lowered ceiling is walked back down.
	assign gated    = (ENV_I <= gate_reg); // [R01]
	assign want_dec = (ENV_I > limit_reg) || (gain_reg > max_reg); // [R16]
	assign dec_fire = !gated && want_dec && tif.dec_ok
		&& (gain_reg != '0); // [R03] [R16]
	assign inc_fire = !gated && !want_dec && (ENV_I < target_reg)
		&& tif.inc_ok && (gain_reg < max_reg); // [R02] [R04] [R16]

	// Gain moves by exactly one step per change.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			gain_reg <= agc_pkg::GAIN_RST;
		end else if (dec_fire) begin
			gain_reg <= gain_reg - agc_pkg::GAIN_STEP; // [R15]
		end else if (inc_fire) begin
			gain_reg <= gain_reg + agc_pkg::GAIN_STEP; // [R15]
		end
	end

	// Remembers that the last change was a decrease, selecting hold once.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			after_dec_reg <= 1'h0;
		end else if (dec_fire) begin
			after_dec_reg <= 1'h1; // [R06]
		end else if (inc_fire) begin
			after_dec_reg <= 1'h0; // [R07]
		end
	end

	// Short detect pin is resynchronised before use.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			short_meta_reg <= 1'h0;
			short_reg      <= 1'h0;
		end else begin
			short_meta_reg <= SHORT_I;
			short_reg      <= short_meta_reg;
		end
	end

	assign short_event = short_reg && (sc_reg == agc_pkg::SC_RUN);

	// Recovery: stage off for the retry period, then a brief probe.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			sc_reg     <= agc_pkg::SC_RUN;
			sc_cnt_reg <= '0;
			out_en_reg <= 1'h1;
		end else begin
			case (sc_reg)
				agc_pkg::SC_RUN: begin
					if (short_reg) begin // [R12]
						sc_reg     <= agc_pkg::SC_OFF;
						sc_cnt_reg <= '0;
						out_en_reg <= 1'h0;
					end
				end
				agc_pkg::SC_OFF: begin
					if (sc_cnt_reg == RETRY_LAST) begin // [R12]
						sc_reg     <= agc_pkg::SC_PROBE;
						sc_cnt_reg <= '0;
						out_en_reg <= 1'h1;
					end else begin
						sc_cnt_reg <= sc_cnt_reg + CW'(1);
					end
				end
				agc_pkg::SC_PROBE: begin
					if (short_reg) begin // [R13]
						sc_reg     <= agc_pkg::SC_OFF;
						sc_cnt_reg <= '0;
						out_en_reg <= 1'h0;
					end else if (sc_cnt_reg == PROBE_LAST) begin // [R13]
						sc_reg     <= agc_pkg::SC_RUN;
						sc_cnt_reg <= '0;
					end else begin
						sc_cnt_reg <= sc_cnt_reg + CW'(1);
					end
				end
				default: begin
					sc_reg     <= agc_pkg::SC_RUN;
					sc_cnt_reg <= '0;
					out_en_reg <= 1'h1;
				end
			endcase
		end
	end

	assign wr_ctrl1 = WR_I && (ADDR_I == agc_pkg::OFS_CTRL1);
	assign wr_stat  = WR_I && (ADDR_I == agc_pkg::OFS_IRQ_STAT);

	// Fault is sticky; a new short in the clearing cycle keeps it set.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			fault_reg <= 1'h0;
		end else begin
			fault_reg <= short_event || (fault_reg
				&& !(wr_ctrl1 && WDATA_I[agc_pkg::CTRL1_FAULT])); // [R14]
		end
	end

	// Interrupt status, write one to clear, set wins.
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_reg & ~WDATA_I[agc_pkg::IRQ_W-1:0];
		end
		stat_next[agc_pkg::IRQ_SHORT] = stat_next[agc_pkg::IRQ_SHORT]
			| short_event;
		stat_next[agc_pkg::IRQ_DOWN] = stat_next[agc_pkg::IRQ_DOWN] | dec_fire;
		stat_next[agc_pkg::IRQ_UP] = stat_next[agc_pkg::IRQ_UP] | inc_fire;
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			stat_reg <= '0;
			irq_reg  <= 1'h0;
		end else begin
			stat_reg <= stat_next;
			irq_reg  <= |(stat_next & mask_reg);
		end
	end

	// Configuration writes.
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			hold_en_reg <= agc_pkg::HOLD_EN_RST;
			attack_reg  <= agc_pkg::ATTACK_RST;
			release_reg <= agc_pkg::RELEASE_RST;
			hold_reg    <= agc_pkg::HOLD_RST;
			gate_reg    <= agc_pkg::GATE_RST;
			limit_reg   <= agc_pkg::LIMIT_RST;
			target_reg  <= agc_pkg::TARGET_RST;
			max_reg     <= agc_pkg::MAXGAIN_RST;
			mask_reg    <= '0;
		end else if (WR_I) begin
			case (ADDR_I)
				agc_pkg::OFS_CTRL1:
					hold_en_reg <= WDATA_I[agc_pkg::CTRL1_HOLD_EN]; // [R08]
				agc_pkg::OFS_ATTACK:   attack_reg  <= WDATA_I;
				agc_pkg::OFS_RELEASE:  release_reg <= WDATA_I;
				agc_pkg::OFS_HOLD:     hold_reg    <= WDATA_I;
				agc_pkg::OFS_GATE:     gate_reg    <= WDATA_I[agc_pkg::EW-1:0];
				agc_pkg::OFS_LIMIT:    limit_reg   <= WDATA_I[agc_pkg::EW-1:0];
				agc_pkg::OFS_TARGET:   target_reg  <= WDATA_I[agc_pkg::EW-1:0];
				agc_pkg::OFS_MAXGAIN:  max_reg     <= WDATA_I[agc_pkg::GW-1:0];
				agc_pkg::OFS_IRQ_MASK:
					mask_reg <= WDATA_I[agc_pkg::IRQ_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Read mux; unmapped addresses and idle cycles read zero.
	always_comb begin
		rdata_next = '0;
		if (RD_I) begin
			case (ADDR_I)
				agc_pkg::OFS_CTRL1: begin
					rdata_next[agc_pkg::CTRL1_HOLD_EN] = hold_en_reg;
					rdata_next[agc_pkg::CTRL1_FAULT]   = fault_reg;
				end
				agc_pkg::OFS_ATTACK:   rdata_next = attack_reg;
				agc_pkg::OFS_RELEASE:  rdata_next = release_reg;
				agc_pkg::OFS_HOLD:     rdata_next = hold_reg;
				agc_pkg::OFS_GATE:     rdata_next[agc_pkg::EW-1:0] = gate_reg;
				agc_pkg::OFS_LIMIT:    rdata_next[agc_pkg::EW-1:0] = limit_reg;
				agc_pkg::OFS_TARGET:   rdata_next[agc_pkg::EW-1:0] = target_reg;
				agc_pkg::OFS_MAXGAIN:  rdata_next[agc_pkg::GW-1:0] = max_reg;
				agc_pkg::OFS_GAIN:     rdata_next[agc_pkg::GW-1:0] = gain_reg;
				agc_pkg::OFS_IRQ_STAT:
					rdata_next[agc_pkg::IRQ_W-1:0] = stat_reg;
				agc_pkg::OFS_IRQ_MASK:
					rdata_next[agc_pkg::IRQ_W-1:0] = mask_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs straight from flops.
	assign RDATA_O  = rdata_reg;
	assign GAIN_O   = gain_reg;
	assign OUT_EN_O = out_en_reg;
	assign FAULT_O  = fault_reg;
	assign IRQ_O    = irq_reg;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	a_gate_freeze: assert property ( // [R01]
		(ENV_I <= gate_reg) |=> $stable(gain_reg))
		else $error("Gain moved while the input was gated.");
	a_gain_ceiling: assert property ( // [R02]
		(gain_reg > $past(gain_reg)) |-> gain_reg <= $past(max_reg))
		else $error("Gain stepped above the maximum.");
	a_attack_space: assert property ( // [R03]
		(gain_reg < $past(gain_reg)) |-> $past(tif.dec_ok))
		else $error("Decrease before the attack interval.");
	a_release_space: assert property ( // [R04]
		(gain_reg > $past(gain_reg)) |-> $past(tif.inc_ok))
		else $error("Increase before the release interval.");
	a_one_step: assert property ( // [R15]
		!$stable(gain_reg) |-> (gain_reg == $past(gain_reg) + 7'h01
		|| gain_reg == $past(gain_reg) - 7'h01))
		else $error("Gain change was not one step.");
	a_short_off: assert property ( // [R12]
		(short_reg && sc_reg == agc_pkg::SC_RUN) |=> !OUT_EN_O ##1 !OUT_EN_O)
		else $error("Output stage not switched off on a short.");
	a_retry_wait: assert property ( // [R12]
		(sc_reg == agc_pkg::SC_OFF && sc_cnt_reg == RETRY_LAST)
		|=> OUT_EN_O && sc_reg == agc_pkg::SC_PROBE)
		else $error("Retry did not follow the retry period.");
	a_probe_return: assert property ( // [R13]
		(sc_reg == agc_pkg::SC_PROBE && !short_reg && sc_cnt_reg == PROBE_LAST)
		|=> sc_reg == agc_pkg::SC_RUN && OUT_EN_O)
		else $error("Clean probe did not resume running.");
	a_fault_sticky: assert property ( // [R14]
		(fault_reg && !(wr_ctrl1 && WDATA_I[agc_pkg::CTRL1_FAULT])) |=> FAULT_O)
		else $error("Fault flag dropped without a clearing write.");
	a_hold_once: assert property ( // [R07]
		(inc_fire) |=> !after_dec_reg)
		else $error("Hold still selected after the first increase.");

	c_gain_down: cover property (dec_fire ##[1:300] dec_fire);
	c_hold_then_up: cover property (dec_fire ##[1:1000] inc_fire);
	c_retry_probe: cover property (sc_reg == agc_pkg::SC_PROBE);
	c_fault_clear: cover property (fault_reg ##1 !fault_reg);
endmodule : agc_gain_step

/* File: verif/audio_src.sv */
// Behavioural audio source that feeds the envelope and the short detect line.
module audio_src (
	input  wire logic                   clk_i,   // System clock.
	output logic      [agc_pkg::EW-1:0] env_o,   // Detected envelope level.
	output logic                        short_o  // Short detect line.
);
	timeunit 1ns;
	timeprecision 1ps;

	// New levels land just after an edge, as a source on this clock would.
	task automatic play(input logic [agc_pkg::EW-1:0] lvl);
		@(posedge clk_i);
		env_o <= lvl;
	endtask : play

	// The short is a level that stays until the load is healthy again.
	task automatic load_short(input logic s);
		@(posedge clk_i);
		short_o <= s;
	endtask : load_short
endmodule : audio_src

/* File: verif/tb.sv */
// Self-checking bench of the gain step control with its audio source.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned T  = 4;
	localparam int unsigned RC = 8;
	typedef struct {logic [7:0] a; logic [15:0] v;} row_s;
	logic        clk, reset, wr, rd, short_det, out_en, fault, irq;
	logic [7:0]  addr, env, env_d;
	logic [15:0] wdata, rdata, d;
	logic [6:0]  gain, prev_gain;
	logic        have_last, last_dec, up, hold_on;
	int          err_total, checks_done, cyc, chg_cnt, last_cyc, n;
	int          attack_c, release_c, hold_c, gate_c, max_c;
	row_s        rows [13];

	agc_gain_step #(.TICK_CYCLES(T), .RETRY_CYCLES(RC)) u_dut (
		.CLK_I(clk), .RESET_I(reset), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ENV_I(env),
		.SHORT_I(short_det), .GAIN_O(gain), .OUT_EN_O(out_en),
		.FAULT_O(fault), .IRQ_O(irq));
	audio_src u_src (.clk_i(clk), .env_o(env), .short_o(short_det));

	// Free running clock of 10 ns.
	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic cmp_reg(input logic [15:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_bit(input logic got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s is %b", $time, what, got);
		end
	endtask : cmp_bit

	// One write cycle; the strobe drops at the edge that takes it.
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : bus_wr

	// Read data stand only in the cycle after the strobe.
	task automatic bus_rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		#1 v = rdata;
	endtask : bus_rd

	// Bounded wait for the next gain change seen by the monitor.
	task automatic wait_chg(input int lim);
		int n0;
		int k;
		n0 = chg_cnt;
		k  = 0;
		while (chg_cnt == n0 && k < lim) begin
			@(posedge clk);
			#1 k++;
		end
		cmp_bit(chg_cnt != n0, 1'b1, "gain change in time");
	endtask : wait_chg

	task automatic wait_out(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (out_en !== lvl && cnt < lim) begin
			@(posedge clk);
			#1 cnt++;
		end
		cmp_bit(out_en, lvl, "output enable");
	endtask : wait_out

	task automatic print_verdict();
		$display("checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	// Watches every gain step; the envelope is taken one edge late because
	// the step lands one edge after the decision.
	always @(posedge clk) begin
		cyc++;
		if (reset) begin
			have_last = 1'b0;
			last_dec  = 1'b0;
		end else if (gain !== prev_gain) begin
			up = (gain == prev_gain + 7'h01);
			cmp_bit(up || gain == prev_gain - 7'h01, 1'b1, "step");
			cmp_bit(env_d > gate_c, 1'b1, "change while gated");
			if (have_last && !up)
				cmp_bit(cyc - last_cyc >= attack_c * T, 1'b1, "attack");
			if (have_last && up)
				cmp_bit(cyc - last_cyc >= ((last_dec && hold_on &&
					hold_c > release_c) ? hold_c : release_c) * T, 1'b1,
					"increase pace");
			if (up)
				cmp_bit(gain <= max_c, 1'b1, "above ceiling");
			have_last = 1'b1;
			last_dec  = !up;
			last_cyc  = cyc;
			chg_cnt++;
		end
		prev_gain = gain;
		env_d     = env;
	end

	// A hang is cut short well beyond the few thousand cycles of the run.
	always @(posedge clk) begin
		if (cyc == 20000) begin
			err_total++;
			$display("unexpected at %0t: run too long", $time);
			print_verdict();
		end
	end

	initial begin
		reset = 1'b1;
		wr    = 1'b0;
		rd    = 1'b0;
		// Start silent with a healthy load, so the gate holds the gain at first.
		fork
			u_src.play(8'h00);
			u_src.load_short(1'b0);
		join_none
		// Pacing keeps attack a hundredth of release, hold above it.
		attack_c  = 1;
		release_c = 100;
		hold_c    = 400;
		gate_c    = 4;
		max_c     = 60;
		hold_on   = 1'b1;
		rows = '{'{8'h01, 16'h0001}, '{8'h02, 16'h0001}, '{8'h03, 16'h0064},
			'{8'h04, 16'h0190}, '{8'h05, 16'h0004}, '{8'h06, 16'h00C0},
			'{8'h07, 16'h0060}, '{8'h08, 16'h003C}, '{8'h09, 16'h000C},
			'{8'h0A, 16'h0000}, '{8'h0B, 16'h0000}, '{8'h00, 16'h0000},
			'{8'hFF, 16'h0000}};
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		// Reset values of every register, unmapped places read as zero.
		foreach (rows[i]) begin
			bus_rd(rows[i].a, d);
			cmp_reg(d, rows[i].v, "reset value");
		end
		// The gain register ignores writes; silence and the gate level freeze.
		bus_wr(agc_pkg::OFS_GAIN, 16'h0055);
		bus_wr(agc_pkg::OFS_IRQ_MASK, 16'h0002);
		bus_rd(agc_pkg::OFS_IRQ_MASK, d);
		cmp_reg(d, 16'h0002, "mask");
		repeat (60) @(posedge clk);
		cmp_reg({9'h000, gain}, 16'h000C, "gain in silence");
		u_src.play(8'h04);
		repeat (60) @(posedge clk);
		cmp_reg({9'h000, gain}, 16'h000C, "gain at gate");
		// Loud input: three decreases at attack pace, then a steady level.
		u_src.play(8'hD0);
		repeat (3) wait_chg(T + 8);
		u_src.play(8'h80);
		repeat (20) @(posedge clk);
		cmp_reg({9'h000, gain}, 16'h0009, "gain after attack");
		cmp_bit(irq, 1'b1, "irq on decrease");
		bus_rd(agc_pkg::OFS_IRQ_STAT, d);
		cmp_reg(d, 16'h0002, "status");
		bus_wr(agc_pkg::OFS_IRQ_STAT, 16'h0002);
		bus_rd(agc_pkg::OFS_IRQ_STAT, d);
		cmp_reg(d, 16'h0000, "status cleared");
		cmp_bit(irq, 1'b0, "irq cleared");
		// Quiet input: hold times the first increase, release the next.
		u_src.play(8'h05);
		wait_chg(hold_c * T + 12);
		wait_chg(release_c * T + 12);
		cmp_reg({9'h000, gain}, 16'h000B, "gain after release");
		// Hold off: release times the first increase after a decrease.
		bus_wr(agc_pkg::OFS_CTRL1, 16'h0000);
		hold_on = 1'b0;
		u_src.play(8'hD0);
		wait_chg(T + 8);
		u_src.play(8'h05);
		wait_chg(release_c * T + 12);
		// Ceiling two steps up is reached and kept.
		bus_wr(agc_pkg::OFS_MAXGAIN, 16'h000D);
		max_c = 13;
		repeat (2) wait_chg(release_c * T + 12);
		repeat (3 * release_c * T) @(posedge clk);
		cmp_reg({9'h000, gain}, 16'h000D, "gain at ceiling");
		// A lowered ceiling pulls the gain down at attack pace.
		bus_wr(agc_pkg::OFS_MAXGAIN, 16'h000B);
		max_c = 11;
		repeat (2) wait_chg(T + 12);
		repeat (20) @(posedge clk);
		cmp_reg({9'h000, gain}, 16'h000B, "gain under ceiling");
		// Short: off, retry after the period, off again while still shorted.
		u_src.load_short(1'b1);
		wait_out(1'b0, 6, n);
		cmp_bit(fault, 1'b1, "fault set");
		wait_out(1'b1, RC + 6, n);
		cmp_bit(n >= RC - 1 && n <= RC + 1, 1'b1, "retry period");
		wait_out(1'b0, agc_pkg::PROBE_CYCLES + 6, n);
		u_src.load_short(1'b0);
		wait_out(1'b1, RC + 6, n);
		repeat (300) @(posedge clk);
		cmp_bit(out_en, 1'b1, "running again");
		cmp_bit(fault, 1'b1, "fault sticky");
		bus_rd(agc_pkg::OFS_CTRL1, d);
		cmp_reg(d, 16'h0008, "control with fault");
		bus_rd(agc_pkg::OFS_IRQ_STAT, d);
		cmp_bit(d[0], 1'b1, "short status");
		bus_wr(agc_pkg::OFS_CTRL1, 16'h0008);
		bus_rd(agc_pkg::OFS_CTRL1, d);
		cmp_reg(d, 16'h0000, "fault cleared");
		cmp_bit(fault, 1'b0, "fault pin cleared");
		// Reset in mid-run brings back the starting gain and settings.
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1 cmp_reg({9'h000, gain}, 16'h000C, "gain after reset");
		cmp_bit(out_en, 1'b1, "output after reset");
		bus_rd(agc_pkg::OFS_CTRL1, d);
		cmp_reg(d, 16'h0001, "control after reset");
		print_verdict();
	end
endmodule : tb
